// ===== core/ssl_pkg.sv
/*
 * Shared definitions of the supply supervisor low-power mode control:
 * register offsets, field positions, reset values, states and timing.
 * Assumes a 25 MHz system clock and a 32-bit APB register bus.
 */
package ssl_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_HIGH_CTL = 8'h00;
    localparam logic [7:0] OFS_LOW_CTL = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_MODE_REQ = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL_W = 6;
    localparam int HI_SUP_EN = 0;
    localparam int HI_SUP_KEEP = 1;
    localparam int HI_SUP_FP = 2;
    localparam int HI_AUTO = 3;
    localparam int HI_MON_EN = 4;
    localparam int HI_MON_FP = 5;
    localparam int LO_SUP_EN = 0;
    localparam int LO_SUP_FP = 1;
    localparam int LO_MON_EN = 2;
    localparam int LO_MON_FP = 3;
    localparam int SIDE_LOW = 0;
    localparam int SIDE_HIGH = 1;
    localparam int EV_LOW_SETTLED = 0;
    localparam int EV_HIGH_SETTLED = 1;
    localparam int EV_AFFECTED = 2;
    localparam int EV_DEEP_REFUSED = 3;
    localparam int EV_W = 4;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [CTL_W-1:0] HIGH_CTL_RST = 6'h00;
    localparam logic [CTL_W-1:0] LOW_CTL_RST = 6'h00;
    localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_SETTLE_FAST_NS = 2000;
    localparam int T_SETTLE_SLOW_NS = 150000;
    localparam int T_WAKE_FAST_NS = 5000;
    localparam int T_WAKE_SLOW_NS = 150000;
    localparam int SETTLE_FAST_CYC = (T_SETTLE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_SLOW_CYC = (T_SETTLE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_FAST_CYC = (T_WAKE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_SLOW_CYC = (T_WAKE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 13;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MON_OFF = 2'b00,
        MON_NORMAL = 2'b01,
        MON_FULL = 2'b10
    } ssl_op_type;

    typedef enum logic [1:0] {
        PM_ACTIVE = 2'b00,
        PM_LIGHT = 2'b01,
        PM_DEEP = 2'b10
    } ssl_mode_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ssl_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ssl_apb_rsp_type;

endpackage : ssl_pkg

// ===== core/ssl_supervisor.sv
/*
 * Supply supervisor low-power mode control: high-side supervisor and
 * monitor state selection per power mode, affected-configuration
 * checker, settling-delay flags and wake-up timing, behind an APB slave.
 * Assumes one 25 MHz clock, synchronous active-high reset, APB master.
 */
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ssl_supervisor
    import ssl_pkg::*;
#(
    parameter int SETTLE_FAST = SETTLE_FAST_CYC,
    parameter int SETTLE_SLOW = SETTLE_SLOW_CYC,
    parameter int WAKE_FAST = WAKE_FAST_CYC,
    parameter int WAKE_SLOW = WAKE_SLOW_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire ssl_apb_req_type apb_req,
    output ssl_apb_rsp_type apb_rsp,
    output logic irq,
    output ssl_op_type hs_sup_state,
    output ssl_op_type hs_mon_state,
    output logic cfg_affected,
    output ssl_mode_type power_mode
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CTL_W-1:0] high_ctl;
        logic [CTL_W-1:0] low_ctl;
        logic [1:0][CNT_W-1:0] settle_cnt;
        logic [1:0] dly_flag;
        logic [EV_W-1:0] ists;
        logic [EV_W-1:0] mask;
        ssl_mode_type mode;
        ssl_mode_type wake_target;
        logic waking;
        logic [CNT_W-1:0] wake_cnt;
        ssl_op_type sup;
        ssl_op_type mon;
        logic affected;
        logic irq;
        ssl_apb_rsp_type rsp;
    } ssl_state_type;

    ssl_state_type st_q;
    ssl_state_type st_d;

    function automatic ssl_op_type active_op(input logic en, input logic fp);
        active_op = !en ? MON_OFF : (fp ? MON_FULL : MON_NORMAL);
    endfunction : active_op

    // Deep mode with auto control drops one level: full to normal, normal to off
    function automatic ssl_op_type auto_op(input logic en, input logic fp);
        auto_op = (en && fp) ? MON_NORMAL : MON_OFF;
    endfunction : auto_op

    // ----------------------------------------------------------------
    // Combinational decode
    // ----------------------------------------------------------------
    logic deep;
    logic low_fast;
    logic hi_sup_hit;
    logic hi_mon_hit;
    logic acc_done;
    logic acc_first;
    logic wr_done;
    logic rd_done;
    logic addr_ok;
    ssl_op_type sup_n;
    ssl_op_type mon_n;

    assign deep = (st_q.mode == PM_DEEP);
    assign acc_first = apb_req.psel && apb_req.penable && !st_q.rsp.pready;
    assign acc_done = apb_req.psel && apb_req.penable && st_q.rsp.pready;
    assign wr_done = acc_done && apb_req.pwrite && !st_q.rsp.pslverr;
    assign rd_done = acc_done && !apb_req.pwrite;
    assign addr_ok = (apb_req.paddr == OFS_HIGH_CTL) || (apb_req.paddr == OFS_LOW_CTL)
        || (apb_req.paddr == OFS_FLAGS) || (apb_req.paddr == OFS_IRQ_STATUS)
        || (apb_req.paddr == OFS_IRQ_MASK) || (apb_req.paddr == OFS_MODE_REQ)
        || (apb_req.paddr == OFS_STATE);

    assign low_fast = !st_q.low_ctl[LO_SUP_EN] || st_q.low_ctl[LO_SUP_FP]
        || !st_q.low_ctl[LO_MON_EN] || st_q.low_ctl[LO_MON_FP];
    assign hi_sup_hit = st_q.high_ctl[HI_SUP_EN] && !st_q.high_ctl[HI_SUP_FP]
        && (!st_q.high_ctl[HI_SUP_KEEP] || st_q.high_ctl[HI_AUTO]);
    assign hi_mon_hit = st_q.high_ctl[HI_MON_EN] && !st_q.high_ctl[HI_MON_FP]
        && st_q.high_ctl[HI_AUTO];

    always_comb begin
        sup_n = active_op(st_q.high_ctl[HI_SUP_EN], st_q.high_ctl[HI_SUP_FP]);
        mon_n = active_op(st_q.high_ctl[HI_MON_EN], st_q.high_ctl[HI_MON_FP]);
        if (deep) begin
            if (!st_q.high_ctl[HI_SUP_KEEP]) begin
                sup_n = MON_OFF;
            end else if (st_q.high_ctl[HI_AUTO]) begin
                sup_n = auto_op(st_q.high_ctl[HI_SUP_EN], st_q.high_ctl[HI_SUP_FP]);
            end
            if (st_q.high_ctl[HI_AUTO]) begin
                mon_n = auto_op(st_q.high_ctl[HI_MON_EN], st_q.high_ctl[HI_MON_FP]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        logic [1:0] wr_side;
        ssl_mode_type req;
        ev = '0;
        clr = '0;
        wr_side = '0;
        req = ssl_mode_type'(apb_req.pwdata[1:0]);
        st_d = st_q;

        // APB answer: ready one cycle into the access phase
        st_d.rsp.pready = acc_first;
        st_d.rsp.pslverr = acc_first && !addr_ok;
        st_d.rsp.prdata = 32'h0000_0000;
        if (acc_first && !apb_req.pwrite) begin
            case (apb_req.paddr)
                OFS_HIGH_CTL: st_d.rsp.prdata[CTL_W-1:0] = st_q.high_ctl;
                OFS_LOW_CTL: st_d.rsp.prdata[CTL_W-1:0] = st_q.low_ctl;
                OFS_FLAGS: st_d.rsp.prdata[1:0] = st_q.dly_flag;
                OFS_IRQ_STATUS: st_d.rsp.prdata[EV_W-1:0] = st_q.ists;
                OFS_IRQ_MASK: st_d.rsp.prdata[EV_W-1:0] = st_q.mask;
                OFS_MODE_REQ: st_d.rsp.prdata[1:0] = st_q.mode;
                OFS_STATE: st_d.rsp.prdata[7:0] = {st_q.waking, st_q.mode,
                    st_q.affected, st_q.mon, st_q.sup};
                default: st_d.rsp.prdata = 32'h0000_0000;
            endcase
        end
        if (rd_done && apb_req.paddr == OFS_IRQ_STATUS) begin
            // Clear only what was reported, so a later event survives
            clr = st_q.rsp.prdata[EV_W-1:0];
        end

        if (wr_done) begin
            case (apb_req.paddr)
                OFS_HIGH_CTL: begin
                    st_d.high_ctl = apb_req.pwdata[CTL_W-1:0];
                    wr_side[SIDE_HIGH] = 1'b1;
                end
                OFS_LOW_CTL: begin
                    st_d.low_ctl = apb_req.pwdata[CTL_W-1:0];
                    wr_side[SIDE_LOW] = 1'b1;
                end
                OFS_IRQ_MASK: st_d.mask = apb_req.pwdata[EV_W-1:0];
                OFS_MODE_REQ: begin
                    if (req == PM_DEEP) begin
                        if (|st_q.dly_flag || st_q.waking) begin
                            ev[EV_DEEP_REFUSED] = 1'b1;
                        end else begin
                            st_d.mode = PM_DEEP;
                        end
                    end else if (req == PM_ACTIVE || req == PM_LIGHT) begin
                        if (deep && !st_q.waking) begin
                            // wake-up time by low supervisor perf bit
                            st_d.waking = 1'b1;
                            st_d.wake_target = req;
                            st_d.wake_cnt = st_q.low_ctl[LO_SUP_FP] ?
                                CNT_W'(WAKE_FAST) : CNT_W'(WAKE_SLOW);
                        end else if (!deep) begin
                            st_d.mode = req;
                        end
                    end
                end
                default: st_d.mode = st_q.mode;
            endcase
        end

        if (st_q.waking) begin
            if (st_q.wake_cnt <= CNT_W'(1)) begin
                st_d.waking = 1'b0;
                st_d.mode = st_q.wake_target;
            end else begin
                st_d.wake_cnt = st_q.wake_cnt - CNT_W'(1);
            end
        end

        for (int s = 0; s < 2; s++) begin
            if (wr_side[s]) begin
                st_d.dly_flag[s] = 1'b1;
                st_d.settle_cnt[s] = ((s == SIDE_LOW) ? st_d.low_ctl[LO_SUP_FP]
                    : st_d.high_ctl[HI_SUP_FP]) ? CNT_W'(SETTLE_FAST) : CNT_W'(SETTLE_SLOW);
            end else if (st_q.dly_flag[s]) begin
                if (st_q.settle_cnt[s] <= CNT_W'(1)) begin
                    st_d.dly_flag[s] = 1'b0;
                    st_d.settle_cnt[s] = '0;
                    ev[s] = 1'b1;
                end else begin
                    st_d.settle_cnt[s] = st_q.settle_cnt[s] - CNT_W'(1);
                end
            end
        end

        st_d.sup = sup_n;
        st_d.mon = mon_n;
        st_d.affected = low_fast && (hi_sup_hit || hi_mon_hit);
        ev[EV_AFFECTED] = st_d.affected && !st_q.affected;

        // Set wins over read-clear
        st_d.ists = (st_q.ists & ~clr) | ev;
        st_d.irq = |(st_d.ists & st_d.mask);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
            st_q.high_ctl <= HIGH_CTL_RST;
            st_q.low_ctl <= LOW_CTL_RST;
            st_q.mask <= IRQ_MASK_RST;
            st_q.mode <= PM_ACTIVE;
            st_q.wake_target <= PM_ACTIVE;
            st_q.sup <= MON_OFF;
            st_q.mon <= MON_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    assign apb_rsp = st_q.rsp;
    assign irq = st_q.irq;
    assign hs_sup_state = st_q.sup;
    assign hs_mon_state = st_q.mon;
    assign cfg_affected = st_q.affected;
    assign power_mode = st_q.mode;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_high_write;
        wr_done && apb_req.paddr == OFS_HIGH_CTL;
    endsequence

    sequence s_deep_wake_req;
        wr_done && apb_req.paddr == OFS_MODE_REQ && deep && !st_q.waking
            && apb_req.pwdata[1:0] == PM_ACTIVE;
    endsequence

    a_sup_active_state: assert property (
        !deep |=> hs_sup_state == $past(
        active_op(st_q.high_ctl[HI_SUP_EN], st_q.high_ctl[HI_SUP_FP])))
        else $error("high supervisor state wrong outside deep mode");

    a_sup_full_perf: assert property (
        !deep && st_q.high_ctl[HI_SUP_EN] && st_q.high_ctl[HI_SUP_FP]
        |=> hs_sup_state == MON_FULL)
        else $error("high supervisor not full outside deep mode");

    a_sup_deep_off: assert property (
        deep && !st_q.high_ctl[HI_SUP_KEEP] |=> hs_sup_state == MON_OFF)
        else $error("high supervisor not off in deep mode without keep");

    a_sup_deep_auto: assert property (
        deep && st_q.high_ctl[HI_SUP_KEEP]
        && st_q.high_ctl[HI_AUTO] && st_q.high_ctl[HI_SUP_EN] |=>
        hs_sup_state == ($past(st_q.high_ctl[HI_SUP_FP]) ? MON_NORMAL : MON_OFF))
        else $error("high supervisor auto drop wrong");

    a_mon_disabled_off: assert property (
        !st_q.high_ctl[HI_MON_EN] |=> hs_mon_state == MON_OFF)
        else $error("high monitor on while disabled");

    a_mon_active_state: assert property (
        !deep && st_q.high_ctl[HI_MON_EN] |=> hs_mon_state ==
        ($past(st_q.high_ctl[HI_MON_FP]) ? MON_FULL : MON_NORMAL))
        else $error("high monitor state wrong outside deep mode");

    a_mon_deep_manual: assert property (
        deep && !st_q.high_ctl[HI_AUTO]
        && st_q.high_ctl[HI_MON_EN] |=> hs_mon_state ==
        ($past(st_q.high_ctl[HI_MON_FP]) ? MON_FULL : MON_NORMAL))
        else $error("high monitor manual deep state wrong");

    a_wake_slow_time: assert property (
        s_deep_wake_req and !st_q.low_ctl[LO_SUP_FP]
        |=> (power_mode == PM_DEEP) [*8])
        else $error("slow wake-up left deep mode too early");

    a_wake_completes: assert property (
        s_deep_wake_req and st_q.low_ctl[LO_SUP_FP]
        |-> ##[1:1000] power_mode == PM_ACTIVE)
        else $error("fast wake-up did not complete");

    a_checker_fast_low: assert property (
        !low_fast |=> !cfg_affected)
        else $error("checker flagged with slow low side");

    a_checker_sup_hit: assert property (
        low_fast && hi_sup_hit |=> cfg_affected)
        else $error("checker missed high supervisor case");

    a_checker_mon_hit: assert property (
        low_fast && hi_mon_hit |=> cfg_affected)
        else $error("checker missed high monitor case");

    a_checker_clear: assert property (
        !hi_sup_hit && !hi_mon_hit |=> !cfg_affected)
        else $error("checker flagged unaffected configuration");

    a_checker_rose_event: assert property (
        $rose(cfg_affected) |-> st_q.ists[EV_AFFECTED])
        else $error("affected rise did not set its status bit");

    a_settle_flag_set: assert property (
        s_high_write |=> st_q.dly_flag[SIDE_HIGH]
        ##1 st_q.dly_flag[SIDE_HIGH])
        else $error("high settle flag not raised by control write");

    a_settle_low_event: assert property (
        $fell(st_q.dly_flag[SIDE_LOW]) |-> st_q.ists[EV_LOW_SETTLED])
        else $error("low settle end did not set its status bit");

    a_deep_refused: assert property (
        wr_done && apb_req.paddr == OFS_MODE_REQ
        && apb_req.pwdata[1:0] == PM_DEEP && (|st_q.dly_flag) && !deep
        |=> power_mode != PM_DEEP && st_q.ists[EV_DEEP_REFUSED])
        else $error("deep entry taken while settling");

    a_irq_level: assert property (|(st_q.ists & st_q.mask) |-> irq)
        else $error("interrupt low with unmasked status");

endmodule : ssl_supervisor

// ===== sim/ssl_supervisor_test.sv
/*
 * Self-checking bench of the supply supervisor low-power mode control:
 * register resets, unmapped access, settle flags, deep refusal, interrupt,
 * high-side state table per mode, configuration checker and wake-up time.
 * Assumes the design's APB slave answers on its own; no other parties.
 */
`timescale 1ns/1ps
`define SSL_CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module ssl_supervisor_test;
    import ssl_pkg::*;

    // ------------------------------------------------------------
    // Shortened counts and bench state
    // ------------------------------------------------------------
    localparam int SF = 4;
    localparam int SS = 10;
    localparam int WF = 4;
    localparam int WS = 10;

    typedef struct packed {
        logic chk;
        logic [31:0] msk;
        logic [31:0] val;
        logic err;
    } ssl_exp_type;

    logic mclk;
    logic rst;
    ssl_apb_req_type apb_req;
    ssl_apb_rsp_type apb_rsp;
    logic irq;
    ssl_op_type hs_sup_state;
    ssl_op_type hs_mon_state;
    logic cfg_affected;
    ssl_mode_type power_mode;
    int n_errors = 0;
    int checks_done = 0;
    ssl_exp_type exp_q[$];
    logic [31:0] seed = 32'h30;
    logic [31:0] rd;

    ssl_supervisor #(
        .SETTLE_FAST(SF),
        .SETTLE_SLOW(SS),
        .WAKE_FAST(WF),
        .WAKE_SLOW(WS)
    ) dut (
        .mclk(mclk),
        .rst(rst),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .irq(irq),
        .hs_sup_state(hs_sup_state),
        .hs_mon_state(hs_mon_state),
        .cfg_affected(cfg_affected),
        .power_mode(power_mode)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // Expected state register: [1:0] sup, [3:2] mon, [4] affected, [6:5] mode
    function automatic logic [31:0] exp_state(logic [5:0] h, logic [3:0] l, ssl_mode_type md);
        logic deep;
        logic fast;
        logic a;
        logic [1:0] s;
        logic [1:0] m;
        deep = (md == PM_DEEP);
        fast = !l[LO_SUP_EN] || l[LO_SUP_FP] || !l[LO_MON_EN] || l[LO_MON_FP];
        if (!h[HI_SUP_EN]) s = MON_OFF;
        else if (!deep || (h[HI_SUP_KEEP] && !h[HI_AUTO])) s = h[HI_SUP_FP] ? MON_FULL : MON_NORMAL;
        else if (!h[HI_SUP_KEEP]) s = MON_OFF;
        else s = h[HI_SUP_FP] ? MON_NORMAL : MON_OFF;
        if (!h[HI_MON_EN]) m = MON_OFF;
        else if (!deep || !h[HI_AUTO]) m = h[HI_MON_FP] ? MON_FULL : MON_NORMAL;
        else m = h[HI_MON_FP] ? MON_NORMAL : MON_OFF;
        a = fast && ((h[HI_SUP_EN] && !h[HI_SUP_FP] && (!h[HI_SUP_KEEP] || h[HI_AUTO]))
            || (h[HI_MON_EN] && !h[HI_MON_FP] && h[HI_AUTO]));
        return {25'h0, md, a, m, s};
    endfunction : exp_state

    // Request held from setup until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       input logic chk, input logic [31:0] msk, input logic [31:0] val,
                       input logic err);
        int n;
        n = 0;
        exp_q.push_back('{chk, msk, val, err});
        @(posedge mclk);
        apb_req <= '{1'b1, 1'b0, wr, addr, wd};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        rd = apb_rsp.prdata;
        apb_req <= '{1'b0, 1'b0, 1'b0, 8'h00, 32'h0};
        if (n >= 20) begin
            n_errors++;
            $display("MISMATCH at %0t: no bus answer", $time);
        end
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd, 1'b0, 32'h0, 32'h0, 1'b0);
    endtask : wr

    task automatic rdc(input logic [7:0] addr, input logic [31:0] msk, input logic [31:0] val);
        apb(1'b0, addr, 32'h0, 1'b1, msk, val, 1'b0);
    endtask : rdc

    // Polling instead of a fixed delay: settle time depends on perf bits
    task automatic wait_settle;
        for (int k = 0; k < 40; k++) begin
            apb(1'b0, OFS_FLAGS, 32'h0, 1'b0, 32'h0, 32'h0, 1'b0);
            if (rd[1:0] == 2'b00) break;
        end
    endtask : wait_settle

    task automatic final_report;
        $display("Errors: %0d, checks: %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Response monitor
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        ssl_exp_type e;
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
            e = exp_q.pop_front();
            `SSL_CHK(apb_rsp.pslverr, e.err)
            if (e.chk) `SSL_CHK(apb_rsp.prdata & e.msk, e.val)
        end
    end

    initial begin
        #(40 * 20000);
        n_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        final_report;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [5:0] h;
        logic [3:0] l;
        logic [31:0] e;
        int n;
        int w;
        ssl_mode_type tgt;
        apb_req = '0;
        rst = 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 28; a += 4) rdc(a[7:0], 32'hFFFFFFFF, 32'h0);
        apb(1'b1, 8'h1C, 32'hFFFFFFFF, 1'b0, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h1C, 32'h0, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b1);
        // Perf bit clear gives the slow interval, so the flag is still seen
        for (int s = 0; s < 2; s++) begin
            wr(s ? OFS_HIGH_CTL : OFS_LOW_CTL, 32'h0);
            rdc(OFS_FLAGS, 32'h1 << s, 32'h1 << s);
            wait_settle;
            rdc(OFS_IRQ_STATUS, 32'h1 << s, 32'h1 << s);
        end
        wr(OFS_LOW_CTL, 32'h0);
        wr(OFS_MODE_REQ, {30'h0, PM_DEEP});
        rdc(OFS_MODE_REQ, 32'h3, {30'h0, PM_ACTIVE});
        `SSL_CHK(irq, 1'b0)
        wr(OFS_IRQ_MASK, 32'h8);
        repeat (2) @(posedge mclk);
        `SSL_CHK(irq, 1'b1)
        rdc(OFS_IRQ_STATUS, 32'h8, 32'h8);
        repeat (2) @(posedge mclk);
        `SSL_CHK(irq, 1'b0)
        wr(OFS_IRQ_MASK, 32'h0);
        wait_settle;
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            h = seed[5:0];
            l = seed[11:8];
            wr(OFS_LOW_CTL, {28'h0, l});
            wr(OFS_HIGH_CTL, {26'h0, h});
            wait_settle;
            rdc(OFS_STATE, 32'h7F, exp_state(h, l, PM_ACTIVE));
            wr(OFS_MODE_REQ, {30'h0, PM_DEEP});
            e = exp_state(h, l, PM_DEEP);
            rdc(OFS_STATE, 32'hFF, e);
            `SSL_CHK(hs_sup_state, e[1:0])
            `SSL_CHK(hs_mon_state, e[3:2])
            `SSL_CHK(cfg_affected, e[4])
            // Alternate the wake target so both requests are exercised
            tgt = i[0] ? PM_ACTIVE : PM_LIGHT;
            wr(OFS_MODE_REQ, {30'h0, tgt});
            n = 0;
            while (power_mode === PM_DEEP && n < 40) begin
                @(posedge mclk);
                n++;
            end
            w = l[LO_SUP_FP] ? WF : WS;
            `SSL_CHK(n >= w - 1 && n <= w + 3, 1'b1)
            rdc(OFS_STATE, 32'hFF, exp_state(h, l, tgt));
            wr(OFS_MODE_REQ, {30'h0, PM_ACTIVE});
        end
        repeat (4) @(posedge mclk);
        final_report;
    end

endmodule : ssl_supervisor_test
